// >>> rtl/sp8_pkg.sv
// Shared constants for the eight-stage serial-in, parallel-out shifter.
package sp8_pkg;

  // Default chain length and word width of the parallel outputs.
  localparam int STAGES = 8;

  // Number of pins that pass the three-flop synchroniser.
  localparam int PIN_CNT = 4;

  // Bit positions of the synchronised pins inside the pin vector.
  localparam int PIN_SCLK  = 0;
  localparam int PIN_SER_A = 1;
  localparam int PIN_SER_B = 2;
  localparam int PIN_CLR_N = 3;

  // Synchroniser reset value: shift clock and clear_n rest high.
  localparam logic [PIN_CNT-1:0] SYNC_RST = 4'h9;

  // Reset value of every storage stage.
  localparam logic [STAGES-1:0] STAGE_RST = 8'h00;

endpackage : sp8_pkg

// >>> rtl/sp8_stream_if.sv
// Valid/ready word carrier between the shifter core and its buffer.
interface sp8_stream_if #(
  parameter int W = 8
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  // The producer drives valid and data, the consumer answers with ready.
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sp8_stream_if

// >>> rtl/sp8_pair_buf.sv
// Two-entry buffer: a registered output stage plus one skid entry.
module sp8_pair_buf #(
  parameter int W = 8
) (
  input  wire logic    core_clk,
  input  wire logic    reset,
  sp8_stream_if.snk    in_if,
  sp8_stream_if.src    out_if
);

  typedef struct packed {
    logic         out_v;
    logic [W-1:0] out_d;
    logic         skid_v;
    logic [W-1:0] skid_d;
  } sp8_buf_s;

  sp8_buf_s buf_reg;
  sp8_buf_s buf_next;
  logic     push;

  // Ready depends only on the skid flop, so it never loops back to valid.
  assign in_if.ready  = ~buf_reg.skid_v;
  assign out_if.valid = buf_reg.out_v;
  assign out_if.data  = buf_reg.out_d;

  // The skid entry catches a word while the output stage is stalled.
  always_comb begin
    buf_next = buf_reg;
    push     = in_if.valid & ~buf_reg.skid_v;
    if (!buf_reg.out_v || out_if.ready) begin
      if (buf_reg.skid_v) begin
        buf_next.out_v  = 1'b1;
        buf_next.out_d  = buf_reg.skid_d;
        buf_next.skid_v = 1'b0;
      end else begin
        buf_next.out_v = push;
        if (push) begin
          buf_next.out_d = in_if.data;
        end
      end
    end else if (push) begin
      buf_next.skid_v = 1'b1;
      buf_next.skid_d = in_if.data;
    end
  end

  // All buffer state registers here.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      buf_reg <= '0;
    end else begin
      buf_reg <= buf_next;
    end
  end

  // A stalled output word must stay put until it is taken.
  property p_out_hold;
    @(posedge core_clk) disable iff (reset)
      out_if.valid && !out_if.ready |=> out_if.valid && $stable(out_if.data);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("Stalled buffer word changed.");

endmodule : sp8_pair_buf

// >>> rtl/sp8_shifter.sv
// Eight-stage serial-in, parallel-out shifter with buffered word stream.
// What this block does
// - Eight chained stages take serial data and show all stages in parallel.
// - Contents advance one stage only on a shift clock rise with clear high.
// - Clear low forces all stages and parallel outputs to zero regardless of inputs.
// - First stage loads one only when both serial inputs are high.
// - Each later stage takes its predecessor's old value; last one drops out.
module sp8_shifter #(
  parameter int STAGES = sp8_pkg::STAGES
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              shift_clk_pin,
  input  wire logic              serial_a,
  input  wire logic              serial_b,
  input  wire logic              clear_n,
  output logic                   stage_out_first,
  output logic [STAGES-2:0]      stage_outs_later,
  output logic                   space_ok,
  output logic                   overrun,
  output logic                   word_valid,
  input  wire logic              word_ready,
  output logic [STAGES-1:0]      word_data
);

  typedef struct packed {
    logic [sp8_pkg::PIN_CNT-1:0] s1;
    logic [sp8_pkg::PIN_CNT-1:0] s2;
    logic [sp8_pkg::PIN_CNT-1:0] s3;
    logic [sp8_pkg::PIN_CNT-1:0] stable;
    logic [STAGES-1:0]           stages;
    logic                        push_v;
    logic [STAGES-1:0]           push_d;
    logic                        overrun;
  } sp8_core_s;

  localparam sp8_core_s CORE_RST = '{
    s1:      sp8_pkg::SYNC_RST,
    s2:      sp8_pkg::SYNC_RST,
    s3:      sp8_pkg::SYNC_RST,
    stable:  sp8_pkg::SYNC_RST,
    stages:  STAGES'(sp8_pkg::STAGE_RST),
    push_v:  1'b0,
    push_d:  STAGES'(sp8_pkg::STAGE_RST),
    overrun: 1'b0
  };

  sp8_core_s                   core_reg;
  sp8_core_s                   core_next;
  logic [sp8_pkg::PIN_CNT-1:0] pins;
  logic                        rise;
  logic                        clr_active;
  logic                        lost;

  sp8_stream_if #(.W(STAGES)) push_if ();
  sp8_stream_if #(.W(STAGES)) pop_if ();

  // Pin vector in the order the package names the bit positions.
  assign pins = {clear_n, serial_b, serial_a, shift_clk_pin};

  // The buffer hides a short receiver stall; a longer one shows as overrun.
  sp8_pair_buf #(.W(STAGES)) sp8_pair_buf_i (
    .core_clk (core_clk),
    .reset    (reset),
    .in_if    (push_if),
    .out_if   (pop_if)
  );

  assign push_if.valid = core_reg.push_v;
  assign push_if.data  = core_reg.push_d;
  assign pop_if.ready  = word_ready;

  // Every output below is a flop of this module or of the buffer.
  assign stage_out_first  = core_reg.stages[0];
  assign stage_outs_later = core_reg.stages[STAGES-1:1];
  assign space_ok         = push_if.ready;
  assign overrun          = core_reg.overrun;
  assign word_valid       = pop_if.valid;
  assign word_data        = pop_if.data;

  // Next-state logic for the whole core.
  // A pin counts as changed once the second and third flops agree, so a
  // glitch shorter than one core clock never reaches the chain. The price
  // is that clear takes effect about four core clocks after the pin falls.
  always_comb begin
    core_next    = core_reg;
    core_next.s1 = pins;
    core_next.s2 = core_reg.s1;
    core_next.s3 = core_reg.s2;
    for (int i = 0; i < sp8_pkg::PIN_CNT; i++) begin
      if (core_reg.s2[i] == core_reg.s3[i]) begin
        core_next.stable[i] = core_reg.s3[i];
      end
    end
    rise       = core_next.stable[sp8_pkg::PIN_SCLK] &
                 ~core_reg.stable[sp8_pkg::PIN_SCLK];
    clr_active = ~core_next.stable[sp8_pkg::PIN_CLR_N];
    lost       = core_reg.push_v & ~push_if.ready;
    core_next.push_v = 1'b0;
    if (clr_active) begin
      core_next.stages = '0;
    end else if (rise) begin
      core_next.stages = {core_reg.stages[STAGES-2:0],
                          core_next.stable[sp8_pkg::PIN_SER_A] &
                          core_next.stable[sp8_pkg::PIN_SER_B]};
      core_next.push_v = 1'b1;
      core_next.push_d = {core_reg.stages[STAGES-2:0],
                          core_next.stable[sp8_pkg::PIN_SER_A] &
                          core_next.stable[sp8_pkg::PIN_SER_B]};
    end
    // Without a rise the stages simply hold, zero after a clear.
    // A lost word sets overrun even in the cycle that clear is seen.
    if (clr_active) begin
      core_next.overrun = 1'b0;
    end
    if (lost) begin
      core_next.overrun = 1'b1;
    end
  end

  // All core state registers here.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      core_reg <= CORE_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  // A word pushed into an empty buffer shows one cycle later and equals
  // the parallel outputs of the shift that produced it.
  property p_word_matches;
    @(posedge core_clk) disable iff (reset)
      core_reg.push_v && !word_valid |=> word_valid &&
        word_data == $past({stage_outs_later, stage_out_first});
  endproperty
  a_word_matches: assert property (p_word_matches)
    else $error("Pushed word differs from the parallel outputs.");

  // Without a shift and with clear released the stages do not move.
  property p_hold_no_rise;
    @(posedge core_clk) disable iff (reset)
      core_reg.stable[sp8_pkg::PIN_CLR_N] && !core_reg.push_v
        |-> core_reg.stages == $past(core_reg.stages);
  endproperty
  a_hold_no_rise: assert property (p_hold_no_rise)
    else $error("Stages changed without a shift clock rise.");

  // A rise of the filtered shift clock shows the shift in the same cycle.
  property p_rise_shifts;
    @(posedge core_clk) disable iff (reset)
      $rose(core_reg.stable[sp8_pkg::PIN_SCLK]) &&
        core_reg.stable[sp8_pkg::PIN_CLR_N] |-> core_reg.push_v;
  endproperty
  a_rise_shifts: assert property (p_rise_shifts)
    else $error("Shift clock rise did not shift the chain.");

  // While clear is seen low every stage reads zero.
  property p_clear_zero;
    @(posedge core_clk) disable iff (reset)
      !core_reg.stable[sp8_pkg::PIN_CLR_N] |-> core_reg.stages == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("A stage is set while clear is active.");

  // A clear pin low for four cycles shows as zero stages one edge later,
  // since the filtered level and the stages update on the fourth edge.
  property p_clear_latency;
    @(posedge core_clk) disable iff (reset)
      !clear_n [*4] |=> core_reg.stages == '0;
  endproperty
  a_clear_latency: assert property (p_clear_latency)
    else $error("Clear pin did not zero the stages in time.");

  // The first stage takes the AND of both serial inputs.
  property p_first_and;
    @(posedge core_clk) disable iff (reset)
      core_reg.push_v |-> core_reg.stages[0] ==
        (core_reg.stable[sp8_pkg::PIN_SER_A] &
         core_reg.stable[sp8_pkg::PIN_SER_B]);
  endproperty
  a_first_and: assert property (p_first_and)
    else $error("First stage does not hold the AND of the serial inputs.");

  // Later stages take the old value of their predecessor.
  property p_chain_moves;
    @(posedge core_clk) disable iff (reset)
      core_reg.push_v |-> core_reg.stages[STAGES-1:1] ==
        $past(core_reg.stages[STAGES-2:0]);
  endproperty
  a_chain_moves: assert property (p_chain_moves)
    else $error("Chain did not move by exactly one stage.");

  // Clear release leaves the chain at zero until a shift happens.
  property p_release_zero;
    @(posedge core_clk) disable iff (reset)
      $rose(core_reg.stable[sp8_pkg::PIN_CLR_N]) && !core_reg.push_v
        |-> core_reg.stages == '0;
  endproperty
  a_release_zero: assert property (p_release_zero)
    else $error("Stages not zero after clear release.");

  // Main scenarios worth seeing in simulation.
  property p_cov_shift_one;
    @(posedge core_clk) disable iff (reset)
      core_reg.push_v && core_reg.stages[0];
  endproperty
  c_cov_shift_one: cover property (p_cov_shift_one);

  property p_cov_clear;
    @(posedge core_clk) disable iff (reset)
      $fell(core_reg.stable[sp8_pkg::PIN_CLR_N]) && core_reg.stages == '0;
  endproperty
  c_cov_clear: cover property (p_cov_clear);

  property p_cov_full;
    @(posedge core_clk) disable iff (reset)
      !push_if.ready && word_valid && !word_ready;
  endproperty
  c_cov_full: cover property (p_cov_full);

  property p_cov_overrun;
    @(posedge core_clk) disable iff (reset)
      $rose(core_reg.overrun);
  endproperty
  c_cov_overrun: cover property (p_cov_overrun);

endmodule : sp8_shifter

// >>> test/sp8_word_sink.sv
// Word consumer model standing at the far end of the shifter's word stream.
module sp8_word_sink (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       stall,
  input  wire logic       word_valid,
  input  wire logic [7:0] word_data,
  output logic            word_ready,
  output logic [7:0]      taken_cnt,
  output logic [7:0]      last_word,
  output logic [7:0]      prev_word
);
  timeunit 1ns;
  timeprecision 1ns;

  // Ready moves on the falling edge so the shifter samples a settled level.
  always @(negedge core_clk) begin
    word_ready <= !stall;
  end

  // Each accepted word is logged; the two newest are kept in order.
  always @(posedge core_clk) begin
    if (reset) begin
      taken_cnt <= 8'h00;
      last_word <= 8'h00;
      prev_word <= 8'h00;
    end else if (word_valid && word_ready) begin
      prev_word <= last_word;
      last_word <= word_data;
      taken_cnt <= taken_cnt + 8'h01;
    end
  end
endmodule : sp8_word_sink

// >>> test/sp8_shifter_tb_top.sv
// Self-checking testbench for the eight-stage shifter and its word stream.
module sp8_shifter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic       core_clk;
  logic       reset;
  logic       shift_clk_pin;
  logic       serial_a;
  logic       serial_b;
  logic       clear_n;
  logic       stall;
  logic       first;
  logic [6:0] later;
  logic       space_ok;
  logic       overrun;
  logic       word_valid;
  logic       word_ready;
  logic [7:0] word_data;
  logic [7:0] taken_cnt;
  logic [7:0] last_word;
  logic [7:0] prev_word;
  logic [7:0] exp_stages;
  logic [7:0] w1;
  int         num_errors;
  int         checks;
  wire  [7:0] stages = {later, first};

  sp8_shifter sp8_shifter_i (.core_clk(core_clk), .reset(reset),
    .shift_clk_pin(shift_clk_pin), .serial_a(serial_a),
    .serial_b(serial_b), .clear_n(clear_n), .stage_out_first(first),
    .stage_outs_later(later), .space_ok(space_ok), .overrun(overrun),
    .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data));

  sp8_word_sink sp8_word_sink_i (.core_clk(core_clk), .reset(reset),
    .stall(stall), .word_valid(word_valid), .word_data(word_data),
    .word_ready(word_ready), .taken_cnt(taken_cnt),
    .last_word(last_word), .prev_word(prev_word));

  // Free-running 50 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Prints the verdict and ends the run.
  task automatic give_verdict;
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  // Pins are held well past the filter depth so each edge is seen once.
  task automatic shift(input logic a, input logic b);
    serial_a = a;
    serial_b = b;
    idle(5);
    shift_clk_pin = 1'b1;
    idle(8);
    shift_clk_pin = 1'b0;
    idle(6);
    if (clear_n) exp_stages = {exp_stages[6:0], a & b};
  endtask : shift

  task automatic check_reset;
    chk("stages", 8'h00, stages);
    chk("word_valid", 8'h00, {7'h00, word_valid});
    chk("space_ok", 8'h01, {7'h00, space_ok});
    chk("overrun", 8'h00, {7'h00, overrun});
  endtask : check_reset

  // Serial pairs 10, 01 and 11, with a one every third shift so the chain carries data.
  task automatic check_and_gate;
    logic [7:0] pa;
    logic [7:0] pb;
    pa = 8'hb7;
    pb = 8'hda;
    for (int i = 0; i < 8; i++) begin
      shift(pa[i], pb[i]);
      chk("stages", exp_stages, stages);
      chk("word", exp_stages, last_word);
    end
    // Pins move but the shift clock does not rise.
    serial_a = ~serial_a;
    idle(10);
    chk("stages", exp_stages, stages);
  endtask : check_and_gate

  // A stalled consumer fills both entries; the third word is dropped.
  task automatic check_overrun;
    int n;
    stall = 1'b1;
    n = taken_cnt;
    shift(1'b1, 1'b1);
    w1 = exp_stages;
    shift(1'b0, 1'b1);
    chk("space_ok", 8'h00, {7'h00, space_ok});
    shift(1'b1, 1'b1);
    chk("overrun", 8'h01, {7'h00, overrun});
    stall = 1'b0;
    for (int i = 0; i < 20 && taken_cnt != n + 2; i++) idle(1);
    // A drain that never finishes is a mismatch and ends the run.
    if (taken_cnt != n + 2) begin
      chk("taken", 8'(n + 2), taken_cnt);
      give_verdict();
    end
    idle(4);
    chk("taken", 8'(n + 2), taken_cnt);
    chk("prev_word", w1, prev_word);
    chk("last_word", {w1[6:0], 1'b0}, last_word);
    chk("space_ok", 8'h01, {7'h00, space_ok});
  endtask : check_overrun

  task automatic check_clear;
    int i;
    clear_n = 1'b0;
    for (i = 0; i < 8 && stages !== 8'h00; i++) idle(1);
    // A clear that never lands is a mismatch and ends the run.
    if (stages !== 8'h00) begin
      chk("stages", 8'h00, stages);
      give_verdict();
    end
    chk("stages", 8'h00, stages);
    shift(1'b1, 1'b1);
    chk("stages", 8'h00, stages);
    chk("overrun", 8'h00, {7'h00, overrun});
    clear_n = 1'b1;
    exp_stages = 8'h00;
    idle(10);
    chk("stages", 8'h00, stages);
    shift(1'b1, 1'b1);
    chk("stages", 8'h01, stages);
  endtask : check_clear

  // Main sequence: reset for four cycles, then each scenario in turn.
  initial begin
    num_errors = 0;
    checks = 0;
    reset = 1'b1;
    shift_clk_pin = 1'b0;
    serial_a = 1'b0;
    serial_b = 1'b0;
    clear_n = 1'b1;
    stall = 1'b0;
    exp_stages = 8'h00;
    // Reset is released after four full rising edges have seen it.
    idle(4);
    reset = 1'b0;
    idle(4);
    check_reset();
    check_and_gate();
    check_overrun();
    check_clear();
    give_verdict();
  end
endmodule : sp8_shifter_tb_top
